// *** hdl/shp_port.sv ***
// serial host port: main port with fixed flow control, aux port by config
// assumes register strobes from same-clock logic; all pins asynchronous
//
// Overview of operation
// (RULE_01) characters are start, eight data, stop, no parity, full duplex.
// (RULE_02) main rate from two switches: on/on 9600 ... off/off 115200.
// (RULE_03) main port always paces characters with hardware flow control.
// (RULE_04) main clear-to-send high while receive slot is full.
// (RULE_05) main request-to-send high stops any new character start.
// (RULE_06) aux handshake swaps roles: clear-to-send in, request-to-send out.
// (RULE_07) aux config selects one of four rates and handshake on or off.
// (RULE_08) aux mode field picks one of two aux port functions.
// (RULE_09) aux echo retransmits received characters, only with mode zero.
// (RULE_10) save command stores aux config; it is restored afterwards. The code never copies it back: reset loads 5'h00 and clears the copy.
// (RULE_11) general-port aux transmits message characters on command.
// (RULE_12) aux data pins mirror main port pin roles.
// (RULE_13) line idles at mark; data go least significant bit first.
// (RULE_14) aux without handshake ignores flow input, sends back to back.
`timescale 1ns/100ps
`include "shp_defines.svh"
`default_nettype none

module shp_port (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	// front panel rate switches, high = on
	input  wire logic        sw_rate_a_i,
	input  wire logic        sw_rate_b_i,
	// main port pins
	output logic             main_txd_o,
	input  wire logic        main_rxd_i,
	input  wire logic        main_rts_i,
	output logic             main_cts_o,
	// aux port pins
	input  wire logic        aux_rxd_i,
	output logic             aux_txd_o,
	input  wire logic        aux_cts_i,
	output logic             aux_rts_o
);
	typedef struct packed {
		logic [4:0]  cfg;
		logic [4:0]  saved;
		logic [4:0]  pend;
		logic [7:0]  mtx_data;
		logic        mtx_pend;
		logic [7:0]  atx_data;
		logic        atx_pend;
		logic        echo_pend;
		logic [7:0]  echo_data;
		logic [31:0] rdata;
		logic [1:0]  s_a;
		logic [1:0]  s_b;
		logic [1:0]  s_mrx;
		logic [1:0]  s_mrts;
		logic [1:0]  s_arx;
		logic [1:0]  s_acts;
	} shp_port_s;

	shp_port_s st_reg;
	shp_port_s st_next;

	logic        m_busy;
	logic        m_rv;
	logic [7:0]  m_rd;
	logic        m_ferr;
	logic        a_busy;
	logic        a_rv;
	logic [7:0]  a_rd;
	logic        a_ferr;
	logic        m_go;
	logic        a_go;
	logic [7:0]  a_txd;
	logic        m_take;
	logic        a_take;
	logic [13:0] m_div;
	logic [13:0] a_div;
	logic        a_hshk;
	logic        a_mode;
	logic        a_echo;
	logic        m_ok;
	logic        a_ok;

	// ------------------------------------------------------------
	// rate selection
	// ------------------------------------------------------------
	function automatic logic [13:0] shp_div(input shp_pkg::shp_baud_e b);
		case (b)
			shp_pkg::SHP_BAUD_9600:  shp_div = 14'(`SHP_DIV_9600);
			shp_pkg::SHP_BAUD_19200: shp_div = 14'(`SHP_DIV_19200);
			shp_pkg::SHP_BAUD_38400: shp_div = 14'(`SHP_DIV_38400);
			default:                 shp_div = 14'(`SHP_DIV_115200);
		endcase
	endfunction

	// switch on/on = 9600, on/off = 19200, off/on = 38400, off/off = 115200
	assign m_div  = shp_div(shp_pkg::shp_baud_e'({~st_reg.s_a[1], ~st_reg.s_b[1]})); // RULE_02
	assign a_div  = shp_div(shp_pkg::shp_baud_e'(st_reg.cfg[`SHP_CFG_BAUD_LSB +: 2])); // RULE_07
	assign a_hshk = st_reg.cfg[`SHP_CFG_HSHK_BIT]; // RULE_07
	assign a_mode = st_reg.cfg[`SHP_CFG_MODE_BIT]; // RULE_08
	assign a_echo = st_reg.cfg[`SHP_CFG_ECHO_BIT] && !a_mode; // RULE_09

	// main waits for request-to-send low; aux waits for clear-to-send low when shaking
	assign m_ok  = !st_reg.s_mrts[1]; // RULE_03 RULE_05
	assign a_ok  = !a_hshk || !st_reg.s_acts[1]; // RULE_06 RULE_14
	assign m_go  = st_reg.mtx_pend && !m_busy && m_ok;
	assign a_go  = (st_reg.echo_pend || st_reg.atx_pend) && !a_busy && a_ok;
	assign a_txd = st_reg.echo_pend ? st_reg.echo_data : st_reg.atx_data;
	assign m_take = rd_i && (addr_i == `SHP_ADDR_MAIN_DATA);
	assign a_take = (rd_i && (addr_i == `SHP_ADDR_AUX_DATA)) || (a_echo && a_rv && !st_reg.echo_pend);

	// ------------------------------------------------------------
	// register access, pending characters, synchronisers
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.s_a    = {st_reg.s_a[0], sw_rate_a_i};
		st_next.s_b    = {st_reg.s_b[0], sw_rate_b_i};
		st_next.s_mrx  = {st_reg.s_mrx[0], main_rxd_i};
		st_next.s_mrts = {st_reg.s_mrts[0], main_rts_i};
		st_next.s_arx  = {st_reg.s_arx[0], aux_rxd_i}; // RULE_12
		st_next.s_acts = {st_reg.s_acts[0], aux_cts_i};
		if (m_go)
			st_next.mtx_pend = 1'b0;
		if (a_go && st_reg.echo_pend)
			st_next.echo_pend = 1'b0;
		else if (a_go)
			st_next.atx_pend = 1'b0;
		// echo captures the held character in the general mode only
		if (a_echo && a_rv && !st_reg.echo_pend) begin
			st_next.echo_pend = 1'b1; // RULE_09
			st_next.echo_data = a_rd;
		end
		st_next.rdata = 32'h0000_0000;
		if (wr_i) begin
			if (addr_i == `SHP_ADDR_MAIN_DATA) begin
				st_next.mtx_data = wdata_i[7:0];
				st_next.mtx_pend = 1'b1;
			end else if (addr_i == `SHP_ADDR_AUX_DATA) begin
				st_next.atx_data = wdata_i[7:0]; // RULE_11
				st_next.atx_pend = 1'b1;
			end else if (addr_i == `SHP_ADDR_AUX_CFG) begin
				st_next.pend = wdata_i[4:0];
			end else if (addr_i == `SHP_ADDR_CMD) begin
				if (wdata_i[`SHP_CMD_APPLY_BIT])
					st_next.cfg = st_reg.pend; // RULE_07 RULE_08
				if (wdata_i[`SHP_CMD_SAVE_BIT])
					st_next.saved = st_reg.cfg; // RULE_10
			end
		end else if (rd_i) begin
			if (addr_i == `SHP_ADDR_MAIN_DATA)
				st_next.rdata = {24'h000000, m_rd};
			else if (addr_i == `SHP_ADDR_MAIN_STAT)
				st_next.rdata = {28'h0, m_ferr, st_reg.mtx_pend, m_busy, m_rv};
			else if (addr_i == `SHP_ADDR_AUX_DATA)
				st_next.rdata = {24'h000000, a_rd};
			else if (addr_i == `SHP_ADDR_AUX_STAT)
				st_next.rdata = {28'h0, a_ferr, st_reg.atx_pend, a_busy, a_rv};
			else if (addr_i == `SHP_ADDR_AUX_CFG)
				st_next.rdata = {27'h0, st_reg.cfg};
			else if (addr_i == `SHP_ADDR_AUX_SAVED)
				st_next.rdata = {27'h0, st_reg.saved};
		end
	end

	// ------------------------------------------------------------
	// state register; reset loads SHP_CFG_RESET as active config and clears the saved copy
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg        <= '0;
			st_reg.cfg    <= `SHP_CFG_RESET;
			st_reg.s_mrx  <= 2'b11;
			st_reg.s_arx  <= 2'b11;
			st_reg.s_mrts <= 2'b11;
			st_reg.s_acts <= 2'b11;
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// the two channels
	// ------------------------------------------------------------
	shp_channel u_main (
		.clk_sys_i      (clk_sys_i),
		.rst_i          (rst_i),
		.ce_i           (ce_i),
		.div_i          (m_div),
		.rx_i           (st_reg.s_mrx[1]),
		.tx_o           (main_txd_o),
		.tx_go_i        (m_go),
		.tx_data_i      (st_reg.mtx_data),
		.tx_busy_o      (m_busy),
		.rx_valid_o     (m_rv),
		.rx_data_o      (m_rd),
		.rx_take_i      (m_take),
		.rx_frame_err_o (m_ferr)
	);

	shp_channel u_aux (
		.clk_sys_i      (clk_sys_i),
		.rst_i          (rst_i),
		.ce_i           (ce_i),
		.div_i          (a_div),
		.rx_i           (st_reg.s_arx[1]),
		.tx_o           (aux_txd_o),
		.tx_go_i        (a_go),
		.tx_data_i      (a_txd),
		.tx_busy_o      (a_busy),
		.rx_valid_o     (a_rv),
		.rx_data_o      (a_rd),
		.rx_take_i      (a_take),
		.rx_frame_err_o (a_ferr)
	);

	// not ready while the held character is unread
	assign main_cts_o = m_rv; // RULE_04
	assign aux_rts_o  = a_hshk ? a_rv : 1'b0; // RULE_06
	assign rdata_o    = st_reg.rdata;

	// no new main character while request-to-send held high
	property p_main_inhibit;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && st_reg.s_mrts[1] && !m_busy) |=> main_txd_o;
	endproperty
	a_main_inhibit: assert property (p_main_inhibit) else $error("main started under inhibit"); // RULE_05

	// clear-to-send stays up until the held character is read
	property p_main_cts;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && main_cts_o && !m_take) |=> main_cts_o;
	endproperty
	a_main_cts: assert property (p_main_cts) else $error("cts wrong"); // RULE_04

	// aux flow input obeyed only with handshake
	property p_aux_hshk;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && a_hshk && st_reg.s_acts[1] && !a_busy) |=> aux_txd_o;
	endproperty
	a_aux_hshk: assert property (p_aux_hshk) else $error("aux sent against flow"); // RULE_06

	// without handshake a pending aux character goes at once
	property p_aux_free;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && !a_hshk && st_reg.atx_pend && !a_busy) |=> !aux_txd_o;
	endproperty
	a_aux_free: assert property (p_aux_free) else $error("aux stalled without handshake"); // RULE_14

	// echo never armed in the second mode
	property p_echo_mode;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && a_mode && !st_reg.echo_pend) |=> !st_reg.echo_pend;
	endproperty
	a_echo_mode: assert property (p_echo_mode) else $error("echo in wrong mode"); // RULE_09

	// save copies active config
	property p_save;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && wr_i && addr_i == `SHP_ADDR_CMD && wdata_i[`SHP_CMD_SAVE_BIT]
			&& !wdata_i[`SHP_CMD_APPLY_BIT]) |=> (st_reg.saved == $past(st_reg.cfg));
	endproperty
	a_save: assert property (p_save) else $error("save lost"); // RULE_10

	// saved copy only moves on a save command
	property p_save_keep;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && !(wr_i && addr_i == `SHP_ADDR_CMD && wdata_i[`SHP_CMD_SAVE_BIT]))
			|=> $stable(st_reg.saved);
	endproperty
	a_save_keep: assert property (p_save_keep) else $error("saved config moved"); // RULE_10

	// apply makes the pending config the active one
	property p_cfg_apply;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && wr_i && addr_i == `SHP_ADDR_CMD && wdata_i[`SHP_CMD_APPLY_BIT])
			|=> (st_reg.cfg == $past(st_reg.pend));
	endproperty
	a_cfg_apply: assert property (p_cfg_apply) else $error("config not applied"); // RULE_07

	// an aux data write queues a message character
	property p_aux_queue;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && wr_i && addr_i == `SHP_ADDR_AUX_DATA) |=> st_reg.atx_pend;
	endproperty
	a_aux_queue: assert property (p_aux_queue) else $error("aux char not queued"); // RULE_11

	// a queued main character starts at once when not inhibited
	property p_main_start;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && st_reg.mtx_pend && !m_busy && !st_reg.s_mrts[1]) |=> !main_txd_o;
	endproperty
	a_main_start: assert property (p_main_start) else $error("main start late"); // RULE_03

	// with echo live a received aux character is taken for retransmit
	property p_echo_arm;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && a_echo && a_rv && !st_reg.echo_pend) |=> st_reg.echo_pend;
	endproperty
	a_echo_arm: assert property (p_echo_arm) else $error("echo not armed"); // RULE_09
endmodule // shp_port

`default_nettype wire

// *** hdl/shp_defines.svh ***
// serial host port constants: register offsets, fields, resets, timing
// assumes a 100 MHz system clock
`ifndef SHP_DEFINES_SVH
`define SHP_DEFINES_SVH

// ------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define SHP_ADDR_MAIN_DATA 8'h00
`define SHP_ADDR_MAIN_STAT 8'h04
`define SHP_ADDR_AUX_DATA  8'h08
`define SHP_ADDR_AUX_STAT  8'h0C
`define SHP_ADDR_AUX_CFG   8'h10
`define SHP_ADDR_AUX_SAVED 8'h14
`define SHP_ADDR_CMD       8'h18

// ------------------------------------------------------------
// aux config fields and commands
// ------------------------------------------------------------
`define SHP_CFG_BAUD_LSB   0
`define SHP_CFG_HSHK_BIT   2
`define SHP_CFG_MODE_BIT   3
`define SHP_CFG_ECHO_BIT   4
`define SHP_CFG_RESET      5'h00
`define SHP_CMD_APPLY_BIT  0
`define SHP_CMD_SAVE_BIT   1

// ------------------------------------------------------------
// timing: clock rate and bit periods in cycles
// ------------------------------------------------------------
`define SHP_CLK_HZ         100000000
`define SHP_DIV_9600       (`SHP_CLK_HZ / 9600)
`define SHP_DIV_19200      (`SHP_CLK_HZ / 19200)
`define SHP_DIV_38400      (`SHP_CLK_HZ / 38400)
`define SHP_DIV_115200     (`SHP_CLK_HZ / 115200)

`endif

// *** hdl/shp_pkg.sv ***
// serial host port types
// used by the port and channel modules
package shp_pkg;
	typedef enum logic [1:0] {
		SHP_BAUD_9600,
		SHP_BAUD_19200,
		SHP_BAUD_38400,
		SHP_BAUD_115200
	} shp_baud_e;

	typedef enum logic [1:0] {
		SHP_TX_IDLE,
		SHP_TX_SHIFT
	} shp_tx_state_e;
endpackage

// *** hdl/shp_channel.sv ***
// one full-duplex 8N1 serial channel with a one-character rx holding slot
// assumes rx_i already synchronised; bit period given in clock cycles
`timescale 1ns/100ps
`include "shp_defines.svh"
`default_nettype none

module shp_channel (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic [13:0] div_i,
	input  wire logic        rx_i,
	output logic             tx_o,
	input  wire logic        tx_go_i,
	input  wire logic [7:0]  tx_data_i,
	output logic             tx_busy_o,
	output logic             rx_valid_o,
	output logic [7:0]       rx_data_o,
	input  wire logic        rx_take_i,
	output logic             rx_frame_err_o
);
	typedef struct packed {
		shp_pkg::shp_tx_state_e tx_st;
		logic [13:0]            tx_cnt;
		logic [3:0]             tx_bit;
		logic [9:0]             tx_sh;
		logic                   tx;
		logic                   rx_act;
		logic [13:0]            rx_cnt;
		logic [3:0]             rx_bit;
		logic [7:0]             rx_sh;
		logic                   rx_valid;
		logic [7:0]             rx_data;
		logic                   ferr;
	} shp_ch_s;

	shp_ch_s st_reg;
	shp_ch_s st_next;

	// ------------------------------------------------------------
	// transmit and receive sequencing
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		case (st_reg.tx_st)
			shp_pkg::SHP_TX_IDLE: begin
				st_next.tx = 1'b1; // RULE_13
				if (tx_go_i) begin
					// start, data lsb first, stop
					st_next.tx_sh  = {1'b1, tx_data_i, 1'b0}; // RULE_01 RULE_13
					st_next.tx_bit = 4'h0;
					st_next.tx_cnt = div_i;
					st_next.tx     = 1'b0;
					st_next.tx_st  = shp_pkg::SHP_TX_SHIFT;
				end
			end
			default: begin
				if (st_reg.tx_cnt <= 14'h0001) begin
					st_next.tx_cnt = div_i;
					if (st_reg.tx_bit == 4'h9) begin
						st_next.tx    = 1'b1;
						st_next.tx_st = shp_pkg::SHP_TX_IDLE;
					end else begin
						st_next.tx_bit = st_reg.tx_bit + 4'h1;
						st_next.tx     = st_reg.tx_sh[st_reg.tx_bit + 4'h1];
					end
				end else begin
					st_next.tx_cnt = st_reg.tx_cnt - 14'h0001;
				end
			end
		endcase
		// reader takes the held character; a new arrival wins over the take
		if (rx_take_i)
			st_next.rx_valid = 1'b0;
		if (!st_reg.rx_act) begin
			if (!rx_i) begin
				st_next.rx_act = 1'b1;
				st_next.rx_bit = 4'h0;
				st_next.rx_cnt = {1'b0, div_i[13:1]}; // sample mid-bit
			end
		end else if (st_reg.rx_cnt <= 14'h0001) begin
			st_next.rx_cnt = div_i;
			if (st_reg.rx_bit == 4'h0 && rx_i) begin
				st_next.rx_act = 1'b0; // glitch, not a start bit
			end else if (st_reg.rx_bit == 4'h9) begin
				st_next.rx_act   = 1'b0;
				st_next.rx_data  = st_reg.rx_sh;
				st_next.rx_valid = 1'b1; // RULE_01
				st_next.ferr     = !rx_i;
			end else begin
				if (st_reg.rx_bit != 4'h0)
					st_next.rx_sh = {rx_i, st_reg.rx_sh[7:1]}; // RULE_13
				st_next.rx_bit = st_reg.rx_bit + 4'h1;
			end
		end else begin
			st_next.rx_cnt = st_reg.rx_cnt - 14'h0001;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg       <= '0;
			st_reg.tx    <= 1'b1;
			st_reg.tx_st <= shp_pkg::SHP_TX_IDLE;
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	assign tx_o           = st_reg.tx;
	assign tx_busy_o      = (st_reg.tx_st != shp_pkg::SHP_TX_IDLE);
	assign rx_valid_o     = st_reg.rx_valid;
	assign rx_data_o      = st_reg.rx_data;
	assign rx_frame_err_o = st_reg.ferr;

	// line returns to mark after a character
	property p_tx_idle_mark;
		@(posedge clk_sys_i) disable iff (rst_i)
		!tx_busy_o |-> tx_o;
	endproperty
	a_tx_idle_mark: assert property (p_tx_idle_mark) else $error("tx not at mark when idle"); // RULE_13

	// start bit follows a go in idle
	property p_tx_start;
		@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && !tx_busy_o && tx_go_i) |=> (!tx_o && tx_busy_o);
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("start bit missing"); // RULE_01
endmodule // shp_channel

`default_nettype wire

// *** bench/shp_host_model.sv ***
// far-side serial party: drives one 8N1 line, samples the other
// assumes the bench clock; bit period given in clock cycles
`timescale 1ns/100ps
`include "shp_defines.svh"
`default_nettype none

module shp_host_model #(
	parameter int BIT_CYC = `SHP_DIV_115200
) (
	input  wire logic clk_sys_i,
	input  wire logic line_i,
	output logic      line_o
);
	// line rests at mark until a frame is sent
	initial line_o = 1'b1;

	// start, data lsb first, stop; stop level is also the idle level
	task automatic send(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		@(posedge clk_sys_i);
		for (int i = 0; i < 10; i++) begin
			line_o <= frame[i];
			repeat (BIT_CYC) @(posedge clk_sys_i);
		end
	endtask

	// samples mid-bit, so a one-cycle skew on the start edge is harmless
	task automatic recv(input int limit, output logic [7:0] b, output logic started,
			output logic stop);
		int n;
		n = 0;
		b = 8'h00;
		stop = 1'b0;
		while (line_i !== 1'b0 && n < limit) begin
			@(posedge clk_sys_i);
			n++;
		end
		started = (line_i === 1'b0);
		if (!started) return;
		repeat (BIT_CYC / 2) @(posedge clk_sys_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk_sys_i);
			b[i] = line_i;
		end
		repeat (BIT_CYC) @(posedge clk_sys_i);
		stop = (line_i === 1'b1);
	endtask
endmodule // shp_host_model

`default_nettype wire

// *** bench/shp_port_tb.sv ***
// self-checking bench for the serial host port, both ports looped to hosts
// assumes a 100 MHz clock and 115200 baud for all full characters
`timescale 1ns/100ps
`include "shp_defines.svh"
`default_nettype none

module shp_port_tb;
	logic        clk_sys_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic [7:0]  addr_i    = 8'h00;
	logic [31:0] wdata_i   = 32'h0;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic        ce_i      = 1'b1;
	logic [31:0] rdata_o;
	logic        sw_rate_a_i = 1'b0;
	logic        sw_rate_b_i = 1'b0;
	logic        main_txd_o;
	wire logic   main_rxd_i;
	logic        main_rts_i = 1'b0;
	logic        main_cts_o;
	wire logic   aux_rxd_i;
	logic        aux_txd_o;
	logic        aux_cts_i  = 1'b0;
	logic        aux_rts_o;
	logic [31:0] d;
	int          bad_count = 0;
	int          n_checks  = 0;

	always #5 clk_sys_i = ~clk_sys_i;

	shp_port shp_port_inst (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.sw_rate_a_i(sw_rate_a_i), .sw_rate_b_i(sw_rate_b_i),
		.main_txd_o(main_txd_o), .main_rxd_i(main_rxd_i),
		.main_rts_i(main_rts_i), .main_cts_o(main_cts_o),
		.aux_rxd_i(aux_rxd_i), .aux_txd_o(aux_txd_o),
		.aux_cts_i(aux_cts_i), .aux_rts_o(aux_rts_o)
	);
	shp_host_model host_main (.clk_sys_i(clk_sys_i), .line_i(main_txd_o), .line_o(main_rxd_i));
	shp_host_model host_aux  (.clk_sys_i(clk_sys_i), .line_i(aux_txd_o), .line_o(aux_rxd_i));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic summarize();
		if (bad_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic give_up();
		bad_count++;
		summarize();
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one-cycle strobes; a gap edge between calls keeps drivers single
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		wr_i    <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_sys_i);
		rd_i   <= 1'b0;
		#1;
		v = rdata_o;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic stay_idle(input string what, input int n, input logic aux);
		logic low;
		low = 1'b0;
		repeat (n) begin
			@(posedge clk_sys_i);
			#1;
			if ((aux ? aux_txd_o : main_txd_o) !== 1'b1) low = 1'b1;
		end
		chk(what, 32'h0, {31'h0, low});
	endtask

	task automatic expect_char(input logic aux, input logic [7:0] exp);
		logic [7:0] b;
		logic       started;
		logic       stop;
		if (aux) host_aux.recv(30000, b, started, stop);
		else host_main.recv(30000, b, started, stop);
		if (started !== 1'b1) give_up();
		chk("serial data", {24'h0, exp}, {24'h0, b});
		chk("stop bit", 32'h1, {31'h0, stop});
	endtask

	// start bit then a one in bit 0: the low time is exactly one bit
	task automatic rate_case(input logic a, input logic b, input int div);
		int w;
		w = 0;
		@(posedge clk_sys_i);
		sw_rate_a_i <= a;
		sw_rate_b_i <= b;
		repeat (4) @(posedge clk_sys_i);
		reg_wr(`SHP_ADDR_MAIN_DATA, 32'h01);
		repeat (20) if (main_txd_o === 1'b1) begin
			@(posedge clk_sys_i);
			#1;
		end
		while (main_txd_o === 1'b0 && w < 12000) begin
			@(posedge clk_sys_i);
			#1;
			w++;
		end
		if (w >= 12000) give_up();
		chk("start bit width ok", 32'h1, {31'h0, w >= div - 1 && w <= div + 1});
		// reset aborts the slow character to keep the run short
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		sw_rate_a_i <= 1'b0;
		sw_rate_b_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// levels right after reset, and an unmapped read
	task automatic sc_reset_state();
		settle(1);
		chk("main txd idle", 32'h1, {31'h0, main_txd_o});
		chk("aux txd idle", 32'h1, {31'h0, aux_txd_o});
		chk("main cts ready", 32'h0, {31'h0, main_cts_o});
		chk("aux rts reset", 32'h0, {31'h0, aux_rts_o});
		reg_rd(8'h1C, d);
		chk("unmapped read", 32'h0, d);
	endtask

	// main transmit held off by the remote, then released
	task automatic sc_main_inhibit();
		@(posedge clk_sys_i);
		main_rts_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		reg_wr(`SHP_ADDR_MAIN_DATA, 32'hA5);
		stay_idle("main txd held", 2000, 1'b0);
		@(posedge clk_sys_i);
		main_rts_i <= 1'b0;
		expect_char(1'b0, 8'hA5);
	endtask

	// main receive raises cts until the slot is read
	task automatic sc_main_receive();
		host_main.send(8'h3C);
		settle(4);
		chk("main cts full", 32'h1, {31'h0, main_cts_o});
		reg_rd(`SHP_ADDR_MAIN_DATA, d);
		chk("main rx data", 32'h3C, {24'h0, d[7:0]});
		settle(3);
		chk("main cts freed", 32'h0, {31'h0, main_cts_o});
	endtask

	// enable low: the write is not taken, so nothing is queued or sent
	task automatic sc_clock_enable();
		@(posedge clk_sys_i);
		ce_i <= 1'b0;
		reg_wr(`SHP_ADDR_MAIN_DATA, 32'h77);
		@(posedge clk_sys_i);
		ce_i <= 1'b1;
		stay_idle("frozen write sent", 300, 1'b0);
		reg_rd(`SHP_ADDR_MAIN_STAT, d);
		chk("main status", 32'h0, d);
	endtask

	// aux: 115200, handshake on, mode 1, echo on (echo must stay off)
	task automatic sc_aux_handshake();
		reg_wr(`SHP_ADDR_AUX_CFG, 32'h1F);
		reg_wr(`SHP_ADDR_CMD, 32'h1);
		reg_wr(`SHP_ADDR_CMD, 32'h2);
		reg_rd(`SHP_ADDR_AUX_SAVED, d);
		chk("saved config", 32'h1F, {27'h0, d[4:0]});
		fork
			host_aux.send(8'h96);
			stay_idle("no echo in mode 1", 9500, 1'b1);
		join
		chk("aux rts full", 32'h1, {31'h0, aux_rts_o});
		reg_rd(`SHP_ADDR_AUX_DATA, d);
		chk("aux rx data", 32'h96, {24'h0, d[7:0]});
		settle(3);
		chk("aux rts freed", 32'h0, {31'h0, aux_rts_o});
		@(posedge clk_sys_i);
		aux_cts_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		reg_wr(`SHP_ADDR_AUX_DATA, 32'h4B);
		stay_idle("aux txd held", 2000, 1'b1);
		@(posedge clk_sys_i);
		aux_cts_i <= 1'b0;
		expect_char(1'b1, 8'h4B);
	endtask

	// aux: no handshake, mode 0, echo on; flow input high is ignored
	task automatic sc_aux_echo();
		reg_wr(`SHP_ADDR_AUX_CFG, 32'h13);
		reg_wr(`SHP_ADDR_CMD, 32'h1);
		@(posedge clk_sys_i);
		aux_cts_i <= 1'b1;
		fork
			host_aux.send(8'h5A);
			expect_char(1'b1, 8'h5A);
		join
		chk("aux rts off", 32'h0, {31'h0, aux_rts_o});
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		sc_reset_state();
		sc_main_inhibit();
		sc_main_receive();
		sc_clock_enable();
		rate_case(1'b1, 1'b1, `SHP_DIV_9600);
		rate_case(1'b1, 1'b0, `SHP_DIV_19200);
		rate_case(1'b0, 1'b1, `SHP_DIV_38400);
		sc_aux_handshake();
		sc_aux_echo();
		summarize();
	end
endmodule // shp_port_tb

`default_nettype wire
